/* File: core/wdsup_consts.svh */
/*
 * Constants of the watchdog supervisor: register offsets, field
 * positions, codes, reset values and time-base figures.
 * Assumes it is included by bare name from the package and top module.
 */
`ifndef WDSUP_CONSTS_SVH
`define WDSUP_CONSTS_SVH

// register offsets
`define WDSUP_ADDR_CTRL      7'h00
`define WDSUP_ADDR_STATUS    7'h05
`define WDSUP_ADDR_NVCFG     7'h74

// control register fields
`define WDSUP_WMC_MSB        7
`define WDSUP_WMC_LSB        5
`define WDSUP_NWP_MSB        3
`define WDSUP_NWP_LSB        0

// operating select codes, any two differ in at least two bits
`define WDSUP_WMC_AUTO       3'h1
`define WDSUP_WMC_TMO        3'h2
`define WDSUP_WMC_WIN        3'h4

// period codes
`define WDSUP_NWP_8MS        4'h8
`define WDSUP_NWP_16MS       4'h1
`define WDSUP_NWP_32MS       4'h2
`define WDSUP_NWP_64MS       4'hB
`define WDSUP_NWP_128MS      4'h4
`define WDSUP_NWP_256MS      4'hD
`define WDSUP_NWP_1024MS     4'hE
`define WDSUP_NWP_4096MS     4'h7
`define WDSUP_NWP_RESET      `WDSUP_NWP_128MS

// nonvolatile config fields and factory presets
`define WDSUP_NV_FORCED_NORMAL_ENABLE_BIT    3
`define WDSUP_NV_SW_DEVELOP_ENABLE_BIT    2
`define WDSUP_NV_FORCED_NORMAL_ENABLE_PRESET 1'b1
`define WDSUP_NV_SW_DEVELOP_ENABLE_PRESET 1'b0

// status register fields
`define WDSUP_ST_FORCED_NORMAL_ACTIVE_BIT    3
`define WDSUP_ST_SW_DEVELOP_ACTIVE_BIT    2
`define WDSUP_PHASE_OFF      2'h0
`define WDSUP_PHASE_FIRST    2'h1
`define WDSUP_PHASE_SECOND   2'h2

// chip operating state codes
`define WDSUP_CHIP_SLEEP     3'h1
`define WDSUP_CHIP_STANDBY   3'h4
`define WDSUP_CHIP_NORMAL    3'h7

// reset source codes
`define WDSUP_RSS_SLEEP_OVF  5'h0C
`define WDSUP_RSS_EARLY      5'h0E
`define WDSUP_RSS_OVERFLOW   5'h0F
`define WDSUP_RSS_ILLEGAL    5'h10

// time base: one watchdog tick is one millisecond
`define WDSUP_CLK_PERIOD_NS  10
`define WDSUP_TICK_NS        1000000
`define WDSUP_TICK_CYCLES    (`WDSUP_TICK_NS / `WDSUP_CLK_PERIOD_NS)
`define WDSUP_PRE_W          17
`define WDSUP_CNT_W          13

`endif

/* File: core/wdsup_pkg.sv */
/*
 * Types of the watchdog supervisor.
 * Assumes wdsup_consts.svh is on the include path.
 */
`include "wdsup_consts.svh"

package wdsup_pkg;

    // effective watchdog operation
    typedef enum logic [1:0] {
        WDSUP_OP_OFF = 2'b00,
        WDSUP_OP_TMO = 2'b01,
        WDSUP_OP_WIN = 2'b10
    } wdsup_op_t;

    // register write strobe with its address and data
    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } wdsup_wr_t;

    // event outputs toward the reset, interrupt and wake logic
    typedef struct packed {
        logic       rst_req;
        logic [4:0] reset_source_code;
        logic       irq_set;
        logic       wake;
        logic       spi_fail;
    } wdsup_evt_t;

    // whole module state
    typedef struct packed {
        logic [2:0]              wd_operating_select;
        logic [3:0]              wd_period_select;
        logic [7:0]              nvcfg;
        logic [`WDSUP_PRE_W-1:0] pre;
        logic [`WDSUP_CNT_W-1:0] cnt;
        logic [1:0]              phase;
        logic [7:0]              rdata;
        wdsup_evt_t              evt;
    } wdsup_state_t;

endpackage : wdsup_pkg

/* File: core/wdsup_top.sv */
/*
 * Watchdog supervisor of a system basis chip: control and status
 * registers, mode resolution, period timer and fault reporting.
 * Assumes a register engine delivering decoded write strobes and read
 * addresses on MCLK, a system controller reporting chip state, and an
 * interrupt controller holding the watchdog interrupt pending flag.
 */
//////////////////////////////////////////////////////////////////////////////
// Contract
// - invalid operating or period code discards the write, flags SPI failure
// - valid operating and period codes differ pairwise in two or more bits
// - forced normal state holds the watchdog off
// - window code acts as window watchdog only in Normal
// - timeout code runs timeout in Normal, Standby and Sleep
// - window code runs timeout in Standby or Sleep
// - autonomous code: timeout in Normal, Standby with irq low; else off
// - software development with autonomous code keeps watchdog off
// - software development makes autonomous the reset operating code
// - window: early trigger or elapsed period requests system reset
// - window: second-half trigger restarts a new period
// - timeout: any trigger before overflow restarts the timer
// - timeout overflow sets the watchdog interrupt flag
// - overflow with interrupt still pending requests system reset
// - timeout overflow in Sleep produces a wake-up event
// - phase field: 00 off, 01 first half, 10 second half
// - status bit 3 forced normal, bit 2 software development
// - forced normal preset 1, software development preset 0
// - valid control write triggers and takes effect at once
// - operating code change in Normal requests reset, source 10000
// - eight periods 8 ms to 4096 ms, default 128 ms
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "wdsup_consts.svh"

module wdsup_top #(
    parameter int TICK_CYCLES = `WDSUP_TICK_CYCLES
) (
    // clock, enable, resets
    input  wire logic                  MCLK,
    input  wire logic                  CE,
    input  wire logic                  NRST,
    input  wire logic                  POR_N,
    // register access
    input  wire wdsup_pkg::wdsup_wr_t  WR,
    input  wire logic [6:0]            RD_ADDR,
    output logic [7:0]                 RD_DATA,
    // chip state
    input  wire logic [2:0]            CHIP_MODE,
    input  wire logic                  FORCED_NORMAL_STATE,
    input  wire logic                  IRQ_OUT_N,
    input  wire logic                  WD_OVERFLOW_IRQ_PEND,
    input  wire logic                  SPI_FAIL_IRQ_EN,
    // events and status
    output wdsup_pkg::wdsup_evt_t      EVT,
    output logic [1:0]                 WD_PHASE_STATE
);

    // elaboration check: prescaler must fit its counter
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << `WDSUP_PRE_W)) begin : g_chk
        $error("wdsup_top: TICK_CYCLES out of range");
    end

    localparam logic [`WDSUP_PRE_W-1:0] TICK_LAST =
        `WDSUP_PRE_W'(TICK_CYCLES - 1);

    wdsup_pkg::wdsup_state_t s_r;
    wdsup_pkg::wdsup_state_t s_nxt;
    wdsup_pkg::wdsup_op_t    op;
    logic [`WDSUP_CNT_W-1:0] period;
    logic [`WDSUP_CNT_W-1:0] half;
    logic [`WDSUP_CNT_W-1:0] new_period;
    logic                    new_period_ok;
    logic                    new_wmc_ok;
    logic [2:0]              new_wmc;
    logic [3:0]              new_nwp;
    logic                    ctrl_wr;
    logic                    trigger;
    logic                    tick;
    logic                    ovf;
    logic                    early;
    logic                    in_normal;
    logic                    in_standby;
    logic                    in_sleep;
    logic [`WDSUP_CNT_W+1:0] new_lut;
    logic [`WDSUP_CNT_W+1:0] cur_lut;
    logic [2:0]              eff_wmc;

    //////////////////////////////////////////////////////////////////////////
    // period lookup, invalid codes decode as not ok
    function automatic logic [`WDSUP_CNT_W+1:0] nwp_ms(input logic [3:0] c);
        logic [`WDSUP_CNT_W+1:0] r;
        r = '0;
        case (c)
            `WDSUP_NWP_8MS:    r = {1'b1, `WDSUP_CNT_W'(8), 1'b0};
            `WDSUP_NWP_16MS:   r = {1'b1, `WDSUP_CNT_W'(16), 1'b0};
            `WDSUP_NWP_32MS:   r = {1'b1, `WDSUP_CNT_W'(32), 1'b0};
            `WDSUP_NWP_64MS:   r = {1'b1, `WDSUP_CNT_W'(64), 1'b0};
            `WDSUP_NWP_128MS:  r = {1'b1, `WDSUP_CNT_W'(128), 1'b0};
            `WDSUP_NWP_256MS:  r = {1'b1, `WDSUP_CNT_W'(256), 1'b0};
            `WDSUP_NWP_1024MS: r = {1'b1, `WDSUP_CNT_W'(1024), 1'b0};
            `WDSUP_NWP_4096MS: r = {1'b1, `WDSUP_CNT_W'(4096), 1'b0};
            default:           r = '0;
        endcase
        return r;
    endfunction : nwp_ms

    //////////////////////////////////////////////////////////////////////////
    // decode of the chip state and the incoming control write
    always_comb begin
        in_normal  = (CHIP_MODE == `WDSUP_CHIP_NORMAL);
        in_standby = (CHIP_MODE == `WDSUP_CHIP_STANDBY);
        in_sleep   = (CHIP_MODE == `WDSUP_CHIP_SLEEP);
        ctrl_wr    = WR.en && (WR.addr == `WDSUP_ADDR_CTRL);
        new_wmc    = WR.data[`WDSUP_WMC_MSB:`WDSUP_WMC_LSB];
        new_nwp    = WR.data[`WDSUP_NWP_MSB:`WDSUP_NWP_LSB];
        // only three one-hot codes pass, distance two apart
        new_wmc_ok = (new_wmc == `WDSUP_WMC_AUTO) ||
                     (new_wmc == `WDSUP_WMC_TMO)  ||
                     (new_wmc == `WDSUP_WMC_WIN);
        new_lut    = nwp_ms(new_nwp);
        {new_period_ok, new_period} = new_lut[`WDSUP_CNT_W+1:1];
        // a valid write is the trigger
        trigger    = ctrl_wr && new_wmc_ok && new_period_ok;
        // a stored new code rules the operation at once
        eff_wmc    = (trigger && !(in_normal && (new_wmc != s_r.wd_operating_select)))
                     ? new_wmc : s_r.wd_operating_select;
    end

    //////////////////////////////////////////////////////////////////////////
    // effective operation from chip state and stored codes
    always_comb begin
        op = wdsup_pkg::WDSUP_OP_OFF;
        if (FORCED_NORMAL_STATE) begin
            op = wdsup_pkg::WDSUP_OP_OFF;
        end else begin
            case (eff_wmc)
                `WDSUP_WMC_WIN: begin
                    if (in_normal) begin
                        op = wdsup_pkg::WDSUP_OP_WIN;
                    end else if (in_standby || in_sleep) begin
                        op = wdsup_pkg::WDSUP_OP_TMO;
                    end
                end
                `WDSUP_WMC_TMO: begin
                    if (in_normal || in_standby || in_sleep) begin
                        op = wdsup_pkg::WDSUP_OP_TMO;
                    end
                end
                `WDSUP_WMC_AUTO: begin
                    if (s_r.nvcfg[`WDSUP_NV_SW_DEVELOP_ENABLE_BIT]) begin
                        op = wdsup_pkg::WDSUP_OP_OFF;
                    end else if (in_normal || (in_standby && !IRQ_OUT_N)) begin
                        op = wdsup_pkg::WDSUP_OP_TMO;
                    end
                end
                default: op = wdsup_pkg::WDSUP_OP_OFF;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // timer compare points of the current period
    always_comb begin
        cur_lut = nwp_ms(s_r.wd_period_select);
        period  = cur_lut[`WDSUP_CNT_W:1];
        half   = period >> 1;
        tick   = (s_r.pre == TICK_LAST);
        ovf    = (op != wdsup_pkg::WDSUP_OP_OFF) && tick &&
                 (s_r.cnt == period - `WDSUP_CNT_W'(1));
        early  = (s_r.cnt < half);
    end

    //////////////////////////////////////////////////////////////////////////
    // next state: registers, timer, events
    always_comb begin
        s_nxt = s_r;
        // event flags are single-cycle pulses; the reset source code holds its value
        s_nxt.evt.rst_req  = 1'b0;
        s_nxt.evt.irq_set  = 1'b0;
        s_nxt.evt.wake     = 1'b0;
        s_nxt.evt.spi_fail = 1'b0;

        // nonvolatile config write, reserved bits kept zero
        if (WR.en && (WR.addr == `WDSUP_ADDR_NVCFG)) begin
            s_nxt.nvcfg = {2'b00, WR.data[5:0]};
        end

        // control write: invalid codes drop the whole access
        if (ctrl_wr && !trigger) begin
            s_nxt.evt.spi_fail = SPI_FAIL_IRQ_EN;
        end else if (trigger && in_normal && (new_wmc != s_r.wd_operating_select)) begin
            s_nxt.evt.rst_req = 1'b1;
            s_nxt.evt.reset_source_code     = `WDSUP_RSS_ILLEGAL;
        end else if (trigger) begin
            s_nxt.wd_operating_select = new_wmc;
            s_nxt.wd_period_select = new_nwp;
        end

        // period timer; an early window trigger is a fault and also restarts the period
        if (op == wdsup_pkg::WDSUP_OP_OFF) begin
            s_nxt.pre   = '0;
            s_nxt.cnt   = '0;
            s_nxt.phase = `WDSUP_PHASE_OFF;
        end else if (trigger && op == wdsup_pkg::WDSUP_OP_WIN && early &&
                     !(in_normal && new_wmc != s_r.wd_operating_select)) begin
            s_nxt.evt.rst_req = 1'b1;
            s_nxt.evt.reset_source_code     = `WDSUP_RSS_EARLY;
            s_nxt.pre         = '0;
            s_nxt.cnt         = '0;
            s_nxt.phase       = `WDSUP_PHASE_FIRST;
        end else if (trigger) begin
            // restart at the start of a new period
            s_nxt.pre   = '0;
            s_nxt.cnt   = '0;
            s_nxt.phase = `WDSUP_PHASE_FIRST;
        end else if (ovf) begin
            s_nxt.pre   = '0;
            s_nxt.cnt   = '0;
            s_nxt.phase = `WDSUP_PHASE_FIRST;
            if (op == wdsup_pkg::WDSUP_OP_WIN) begin
                s_nxt.evt.rst_req = 1'b1;
                s_nxt.evt.reset_source_code     = `WDSUP_RSS_OVERFLOW;
            end else if (WD_OVERFLOW_IRQ_PEND) begin
                s_nxt.evt.rst_req = 1'b1;
                s_nxt.evt.reset_source_code     = `WDSUP_RSS_OVERFLOW;
            end else begin
                s_nxt.evt.irq_set = 1'b1;
                s_nxt.evt.wake    = in_sleep;
                if (in_sleep) begin
                    s_nxt.evt.reset_source_code = `WDSUP_RSS_SLEEP_OVF;
                end
            end
        end else begin
            // prescaled tick advances the period count
            s_nxt.pre = tick ? '0 : s_r.pre + `WDSUP_PRE_W'(1);
            if (tick) begin
                s_nxt.cnt = s_r.cnt + `WDSUP_CNT_W'(1);
            end
            s_nxt.phase = (s_nxt.cnt < half) ? `WDSUP_PHASE_FIRST
                                             : `WDSUP_PHASE_SECOND;
        end

        // registered read port, unmapped addresses read zero
        case (RD_ADDR)
            `WDSUP_ADDR_CTRL:   s_nxt.rdata = {s_r.wd_operating_select, 1'b0, s_r.wd_period_select};
            `WDSUP_ADDR_STATUS: s_nxt.rdata = {4'h0,
                                    FORCED_NORMAL_STATE,
                                    s_r.nvcfg[`WDSUP_NV_SW_DEVELOP_ENABLE_BIT],
                                    s_r.phase};
            `WDSUP_ADDR_NVCFG:  s_nxt.rdata = s_r.nvcfg;
            default:            s_nxt.rdata = 8'h00;
        endcase

        // system reset: timer off, default codes
        if (!NRST) begin
            s_nxt.wd_operating_select   = s_r.nvcfg[`WDSUP_NV_SW_DEVELOP_ENABLE_BIT] ? `WDSUP_WMC_AUTO
                                                       : `WDSUP_WMC_TMO;
            s_nxt.wd_period_select   = `WDSUP_NWP_RESET;
            s_nxt.pre   = '0;
            s_nxt.cnt   = '0;
            s_nxt.phase = `WDSUP_PHASE_OFF;
            s_nxt.rdata = 8'h00;
            s_nxt.evt   = '0;
        end
        // power-on loads the factory presets of the config bits
        if (!POR_N) begin
            s_nxt.nvcfg = '0;
            s_nxt.nvcfg[`WDSUP_NV_FORCED_NORMAL_ENABLE_BIT] = `WDSUP_NV_FORCED_NORMAL_ENABLE_PRESET;
            s_nxt.nvcfg[`WDSUP_NV_SW_DEVELOP_ENABLE_BIT] = `WDSUP_NV_SW_DEVELOP_ENABLE_PRESET;
            s_nxt.wd_operating_select   = `WDSUP_WMC_TMO;
            s_nxt.wd_period_select   = `WDSUP_NWP_RESET;
            s_nxt.pre   = '0;
            s_nxt.cnt   = '0;
            s_nxt.phase = `WDSUP_PHASE_OFF;
            s_nxt.rdata = 8'h00;
            s_nxt.evt   = '0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // state register; resets act even with CE low so startup is defined
    always_ff @(posedge MCLK) begin
        if (CE || !NRST || !POR_N) begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign RD_DATA        = s_r.rdata;
    assign EVT            = s_r.evt;
    assign WD_PHASE_STATE = s_r.phase;

endmodule : wdsup_top

/* File: tb/wdsup_chk_asserts.sv */
/* checker of the watchdog supervisor top ports.
   assumes wdsup_pkg is compiled first; bound at the foot. */
`timescale 1ns/1ns
module wdsup_chk #(
    parameter int TICK_CYCLES = 4
) (
    // clock and resets
    input wire logic                  MCLK,
    input wire logic                  NRST,
    input wire logic                  POR_N,
    // register side
    input wire wdsup_pkg::wdsup_wr_t  WR,
    input wire logic [6:0]            RD_ADDR,
    input wire logic [7:0]            RD_DATA,
    // chip state
    input wire logic [2:0]            CHIP_MODE,
    input wire logic                  FORCED_NORMAL_STATE,
    input wire logic                  WD_OVERFLOW_IRQ_PEND,
    input wire logic                  SPI_FAIL_IRQ_EN,
    // events and phase
    input wire wdsup_pkg::wdsup_evt_t EVT,
    input wire logic [1:0]            WD_PHASE_STATE
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST || !POR_N);
    // both code fields hold a listed value
    wire logic ok = WR.data[7:5] inside {3'h1, 3'h2, 3'h4} &&
        WR.data[3:0] inside {4'h8, 4'h1, 4'h2, 4'hB, 4'h4, 4'hD,
        4'hE, 4'h7};
    // refused and accepted control writes
    sequence s_bad;
        WR.en && WR.addr == 7'h00 && !ok;
    endsequence
    sequence s_tmo_stby;
        WR.en && WR.addr == 7'h00 && ok && WR.data[7:5] == 3'h2 &&
            CHIP_MODE == 3'h4 && !FORCED_NORMAL_STATE;
    endsequence
////////////////////////////////////////
    a_phase_not_rsvd: assert property (WD_PHASE_STATE != 2'h3)
        else $error("phase field holds reserved value");
    a_bad_code_drop: assert property (
        s_bad ##0 SPI_FAIL_IRQ_EN |=> EVT.spi_fail && !EVT.rst_req)
        else $error("refused write gave no spi failure pulse");
    a_tmo_restart: assert property (
        s_tmo_stby |=> WD_PHASE_STATE == 2'h1)
        else $error("timeout trigger did not restart period");
    a_fnm_off: assert property (
        FORCED_NORMAL_STATE [*2] |-> WD_PHASE_STATE == 2'h0)
        else $error("watchdog runs in forced normal state");
    a_other_off: assert property (
        !(CHIP_MODE inside {3'h1, 3'h4, 3'h7}) [*2]
        |-> WD_PHASE_STATE == 2'h0)
        else $error("watchdog runs in another chip state");
    a_irq_pend: assert property (
        EVT.irq_set |-> !$past(WD_OVERFLOW_IRQ_PEND))
        else $error("flag set while one was pending");
    a_rst_src: assert property (
        EVT.rst_req |-> EVT.reset_source_code inside {5'h0E, 5'h0F, 5'h10})
        else $error("reset request with wrong source");
    a_wake_sleep: assert property (
        EVT.wake |-> EVT.reset_source_code == 5'h0C && $past(CHIP_MODE) == 3'h1)
        else $error("wake event outside sleep overflow");
    a_status_read: assert property (
        $past(NRST) && $past(POR_N) && $past(RD_ADDR) == 7'h05
        |-> RD_DATA[7:3] == {4'h0, $past(FORCED_NORMAL_STATE)})
        else $error("status read upper bits wrong");
endmodule : wdsup_chk

bind wdsup_top wdsup_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .MCLK(MCLK), .NRST(NRST), .POR_N(POR_N), .WR(WR),
    .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .CHIP_MODE(CHIP_MODE),
    .FORCED_NORMAL_STATE(FORCED_NORMAL_STATE),
    .WD_OVERFLOW_IRQ_PEND(WD_OVERFLOW_IRQ_PEND),
    .SPI_FAIL_IRQ_EN(SPI_FAIL_IRQ_EN), .EVT(EVT),
    .WD_PHASE_STATE(WD_PHASE_STATE));

/* File: tb/wdsup_mcu.sv */
/* microcontroller model: register writes and reads.
   assumes callers enter its tasks at falling edges. */
`timescale 1ns/1ns
module wdsup_mcu (
    // clock
    input wire logic             MCLK,
    // register side
    output wdsup_pkg::wdsup_wr_t WR,
    output logic [6:0]           RD_ADDR,
    input wire logic [7:0]       RD_DATA
);
    // idle: no strobe, read points at an unmapped place
    initial begin
        WR = '0;
        RD_ADDR = 7'h7F;
    end
    // one-cycle strobe; released fields go inverted so nothing
    // downstream can lean on a stale value
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge MCLK);
        WR <= '{en: 1'b1, addr: a, data: d};
        @(negedge MCLK);
        WR <= '{en: 1'b0, addr: ~a, data: ~d};
    endtask : wr
    // data is registered, so it is taken one cycle later
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge MCLK);
        RD_ADDR <= a;
        @(negedge MCLK);
        d = RD_DATA;
        RD_ADDR <= 7'h7F;
    endtask : rd
endmodule : wdsup_mcu

/* File: tb/wdsup_bench.sv */
/* bench of the watchdog supervisor, a short tick of 4 cycles.
   assumes core/ and the model files are compiled first. */
`timescale 1ns/1ns
module wdsup_bench;
    localparam int RST = 8, IRQ = 2, WAK = 1, SPF = 0;
    localparam logic [2:0] SLP = 3'h1, STB = 3'h4, NRM = 3'h7;
    logic                  clk = 0, rst_n = 0, por_n = 0;
    logic [2:0]            mode = STB;
    logic                  forced_normal_state = 0, irq_n = 1, pend = 0, spi_en = 1;
    logic [7:0]            rdat, v;
    logic [6:0]            radr;
    logic [1:0]            ph;
    logic                  h;
    wdsup_pkg::wdsup_wr_t  wr;
    wdsup_pkg::wdsup_evt_t evt;
    int                    err_count = 0, compares = 0;
////////////////////////////////////////
    // clock enable tied high: freezing is outside these scenarios
    wdsup_top #(.TICK_CYCLES(4)) dut_u (.MCLK(clk), .CE(1'b1),
        .NRST(rst_n), .POR_N(por_n), .WR(wr), .RD_ADDR(radr),
        .RD_DATA(rdat), .CHIP_MODE(mode), .FORCED_NORMAL_STATE(forced_normal_state),
        .IRQ_OUT_N(irq_n), .WD_OVERFLOW_IRQ_PEND(pend),
        .SPI_FAIL_IRQ_EN(spi_en), .EVT(evt), .WD_PHASE_STATE(ph));
    wdsup_mcu mcu (.MCLK(clk), .WR(wr), .RD_ADDR(radr), .RD_DATA(rdat));
    always #5 clk = ~clk;
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // poll one pulse bit for up to n falling edges
    task automatic ev(input int b, input int n, output logic hit);
        hit = 0;
        for (int i = 0; i < n && !hit; i++) begin
            hit = evt[b];
            if (!hit) @(negedge clk);
        end
    endtask : ev
    task automatic t_reset;
        mcu.rd(7'h74, v);
        chk("cfg", 8'h08, v);
        mcu.rd(7'h00, v);
        chk("ctl", 8'h44, v);
        mcu.rd(7'h05, v);
        chk("stat", 8'h01, v);
        mcu.rd(7'h33, v);
        chk("unmapped", 8'h00, v);
        $display("reset test done");
    endtask : t_reset
    // every operating and period code; refused ones flag
    task automatic t_codes;
        logic [7:0] d;
        logic       bad;
        for (int c = 0; c < 24; c++) begin
            d = c < 8 ? {c[2:0], 5'h08} : {4'h4, 4'(c - 8)};
            bad = !(d[7:5] inside {3'h1, 3'h2, 3'h4} && d[3:0] inside
                {4'h8, 4'h1, 4'h2, 4'hB, 4'h4, 4'hD, 4'hE, 4'h7});
            mcu.wr(7'h00, d);
            ev(SPF, 2, h);
            chk("spi_fail", {7'h0, bad}, {7'h0, h});
        end
        spi_en = 0;
        mcu.wr(7'h00, 8'h68);
        ev(SPF, 2, h);
        chk("masked", 8'h00, {7'h0, h});
        spi_en = 1;
        mcu.rd(7'h00, d);
        chk("ctl kept", 8'h4E, d);
        $display("code test done");
    endtask : t_codes
    task automatic t_tmo;
        mcu.wr(7'h00, 8'h48);
        repeat (20) @(negedge clk);
        mcu.wr(7'h00, 8'h48);
        ev(IRQ, 26, h);
        chk("early irq", 8'h00, {7'h0, h});
        ev(IRQ, 20, h);
        chk("irq_set", 8'h01, {7'h0, h});
        pend = 1;
        ev(RST, 40, h);
        chk("rst_req", 8'h01, {7'h0, h});
        chk("rss", 8'h0F, {3'h0, evt.reset_source_code});
        pend = 0;
        mode = SLP;
        ev(WAK, 40, h);
        chk("wake", 8'h01, {7'h0, h});
        chk("rss", 8'h0C, {3'h0, evt.reset_source_code});
        mode = STB;
        $display("timeout test done");
    endtask : t_tmo
    task automatic t_win;
        mcu.wr(7'h00, 8'h88);
        chk("stby win", 8'h01, {6'h0, ph});
        mode = NRM;
        mcu.wr(7'h00, 8'h88);
        ev(RST, 3, h);
        chk("early", 8'h01, {7'h0, h});
        chk("rss", 8'h0E, {3'h0, evt.reset_source_code});
        for (int i = 0; i < 40 && ph !== 2'h2; i++) @(negedge clk);
        mcu.wr(7'h00, 8'h88);
        ev(RST, 3, h);
        chk("late trig", 8'h00, {7'h0, h});
        chk("restart", 8'h01, {6'h0, ph});
        mcu.wr(7'h00, 8'h48);
        ev(RST, 3, h);
        chk("mode chg", 8'h01, {7'h0, h});
        chk("rss", 8'h10, {3'h0, evt.reset_source_code});
        mcu.rd(7'h00, v);
        chk("ctl kept", 8'h88, v);
        ev(RST, 40, h);
        chk("overflow", 8'h01, {7'h0, h});
        chk("rss", 8'h0F, {3'h0, evt.reset_source_code});
        mode = STB;
        $display("window test done");
    endtask : t_win
    // autonomous code across chip states, then overrides
    task automatic t_modes;
        mcu.wr(7'h00, 8'h28);
        chk("auto irq hi", 8'h00, {6'h0, ph});
        irq_n = 0;
        repeat (2) @(negedge clk);
        chk("auto irq lo", 8'h01, {6'h0, ph});
        mode = SLP;
        repeat (2) @(negedge clk);
        chk("auto sleep", 8'h00, {6'h0, ph});
        mode = 3'h2;
        repeat (2) @(negedge clk);
        chk("other", 8'h00, {6'h0, ph});
        mode = NRM;
        forced_normal_state = 1;
        repeat (2) @(negedge clk);
        chk("forced", 8'h00, {6'h0, ph});
        mcu.rd(7'h05, v);
        chk("stat fnm", 8'h08, v);
        forced_normal_state = 0;
        repeat (2) @(negedge clk);
        chk("auto normal", 8'h01, {6'h0, ph});
        mode = STB;
        mcu.wr(7'h74, 8'h0C);
        rst_n = 0;
        repeat (2) @(negedge clk);
        rst_n = 1;
        mcu.rd(7'h00, v);
        chk("sd ctl", 8'h24, v);
        mode = NRM;
        repeat (2) @(negedge clk);
        chk("sd off", 8'h00, {6'h0, ph});
        mcu.rd(7'h05, v);
        chk("stat sd", 8'h04, v);
        $display("mode test done");
    endtask : t_modes
    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // main sequence: power-on reset held six cycles
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1;
        por_n = 1;
        t_reset();
        t_codes();
        t_tmo();
        t_win();
        t_modes();
        give_verdict();
    end
    // scenarios need about 300 cycles; allow over sixty times that
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule : wdsup_bench
